// ==== design/baud_timer.v ====
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_regs.vh"

module baud_timer (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       tick_i,
    input  wire       enable_i,
    input  wire [7:0] reload_i,
    input  wire       low_write_i,
    input  wire [7:0] low_data_i,
    input  wire       rx_restart_i,
    output wire [7:0] low_count_o,
    output reg        tx_ovf_o,
    output reg        rx_ovf_o
);

    reg  [7:0] low_reg;
    reg  [7:0] rx_copy_reg;

    ////////////////////////////////////////////////////////////////////////
    // Visible counter: auto-reload on overflow, drives the transmit clock
    always @(posedge clk_i) begin
        if (rst_i) begin
            low_reg  <= 8'h00;
            tx_ovf_o <= 1'b0;
        end else begin
            tx_ovf_o <= 1'b0;
            if (low_write_i) begin
                low_reg <= low_data_i;
            end else if (enable_i && tick_i) begin
                if (low_reg == `TIMER_TOP) begin
                    low_reg  <= reload_i;             // see R7
                    tx_ovf_o <= 1'b1;                 // see R8
                end else begin
                    low_reg <= low_reg + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hidden copy for the receiver, forced to reload on a start edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_copy_reg <= 8'h00;
            rx_ovf_o    <= 1'b0;
        end else begin
            rx_ovf_o <= 1'b0;
            if (rx_restart_i) begin
                rx_copy_reg <= reload_i;              // see R11
            end else if (enable_i && tick_i) begin    // see R10
                if (rx_copy_reg == `TIMER_TOP) begin
                    rx_copy_reg <= reload_i;          // see R10
                    rx_ovf_o    <= 1'b1;              // see R8
                end else begin
                    rx_copy_reg <= rx_copy_reg + 8'h01;
                end
            end
        end
    end

    assign low_count_o = low_reg;

endmodule // baud_timer

`default_nettype wire

// ==== design/serial_port_zero.v ====
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_regs.vh"

// Behaviour
// R1 - Transmit and receive run independently, simultaneously
// R2 - Receiver holds one byte while shifting next
// R3 - Data write loads and starts transmission
// R4 - Data read returns receive buffer only
// R5 - Done flags raise enabled interrupt
// R6 - Flags stay set until software clears
// R7 - Baud timer is 8-bit auto-reload counter
// R8 - Transmit from visible counter, receive from copy
// R9 - Both overflow streams divided by two
// R10 - Receive copy counts, same reload value
// R11 - Start edge forces receive copy reload
// R12 - Six selectable timer clock sources
// R13 - Baud equals clock over (256-reload), halved
// R14 - Software picks reload for twice baud
// R15 - 8-bit frame: start, 8 LSB-first, stop
// R16 - 9-bit frame adds programmable ninth bit
// R17 - Load only if flag clear, filter passes
// R18 - Transmit done set at stop bit start
// R19 - Idle high, falling-edge start, mid-bit sampling
module serial_port_zero (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [31:0] dat_i,
    input  wire [3:0]  sel_i,
    output wire        ack_o,
    output reg  [31:0] dat_o,
    output wire        irq_o,
    input  wire        serial_rx_pin_i,
    output reg         serial_tx_pin_o,
    input  wire        ext_osc_i,
    input  wire        timer_ext_clock_input_i
);

    localparam RX_IDLE  = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_DATA  = 2'd2;

    // Frame length in bit periods for the selected mode
    function [3:0] frame_bits;
        input mode9;
        begin
            frame_bits = mode9 ? `FRAME9_BITS : `FRAME8_BITS;
        end
    endfunction

    reg        ack_reg;
    reg  [7:0] rd_clear_mask_reg;
    reg        frame_length_select;
    reg        multiproc_filter_enable;
    reg        receiver_enable;
    reg        tx_ninth_bit;
    reg        rx_ninth_bit;
    reg        tx_done_flag;
    reg        rx_done_flag;
    reg  [7:0] serial_data_buffer;
    reg  [7:0] baud_timer_reload;
    reg  [3:0] timer_ctl_reg;
    reg  [1:0] int_status_reg;
    reg  [1:0] int_mask_reg;
    reg  [1:0] pre4_reg;
    reg  [3:0] pre12_reg;
    reg  [1:0] pre48_reg;
    reg  [2:0] extdiv_reg;
    reg        ext_osc_prev_reg;
    reg        ext_pin_prev_reg;
    reg        timer_tick;
    reg        tx_phase_reg;
    reg        rx_phase_reg;
    reg [10:0] tx_shift_reg;
    reg  [3:0] tx_cnt_reg;
    reg        tx_active_reg;
    reg  [1:0] rx_state_reg;
    reg  [9:0] rx_shift_reg;
    reg  [3:0] rx_cnt_reg;
    reg        rx_prev_reg;
    wire       tx_set;
    wire       rx_set;
    wire [7:0] rx_load_data;
    wire       rx_load_ninth;
    reg  [7:0] rd_data;

    wire       req     = cyc_i & stb_i;
    wire       act     = req & ack_reg;
    wire       wr_act  = act & we_i & sel_i[0];
    wire [5:0] idx     = adr_i[7:2];
    wire       wr_ctl  = wr_act && (idx == `IDX_SERIAL_CONTROL);
    wire       wr_data = wr_act && (idx == `IDX_SERIAL_DATA);
    wire       wr_low  = wr_act && (idx == `IDX_BAUD_LOW_COUNT);
    wire [2:0] src_sel = timer_ctl_reg[`TCTL_SRC_MSB:`TCTL_SRC_LSB];
    wire       tmr_en  = timer_ctl_reg[`TCTL_EN_BIT];
    wire [7:0] low_count;
    wire       tx_ovf;
    wire       rx_ovf;
    wire       tx_bit_tick = tx_ovf & tx_phase_reg;
    wire       rx_sample   = rx_ovf & ~rx_phase_reg;
    wire       rx_restart  = (rx_state_reg == RX_IDLE) & receiver_enable
                             & rx_prev_reg & ~serial_rx_pin_i;
    wire [9:0] rx_shift_next = {serial_rx_pin_i, rx_shift_reg[9:1]};
    wire [7:0] scr_value = {frame_length_select, `SCR_RSVD_VAL, multiproc_filter_enable,
                            receiver_enable, tx_ninth_bit, rx_ninth_bit,
                            tx_done_flag, rx_done_flag};

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, ack for one cycle, unmapped reads zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg           <= 1'b0;
            dat_o             <= 32'h0000_0000;
            rd_clear_mask_reg <= 8'h00;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req && !ack_reg) begin
                dat_o             <= {24'h00_0000, rd_data};
                rd_clear_mask_reg <= (!we_i && idx == `IDX_INT_STATUS) ?
                                     {6'h00, int_status_reg} : 8'h00;
            end
        end
    end

    assign ack_o = ack_reg;

    // Read multiplexer; transmit register is never visible
    always @* begin
        case (idx)
            `IDX_SERIAL_CONTROL: rd_data = scr_value;
            `IDX_SERIAL_DATA:    rd_data = serial_data_buffer;    // see R4
            `IDX_TIMER_CONTROL:  rd_data = {4'h0, timer_ctl_reg};
            `IDX_BAUD_RELOAD:    rd_data = baud_timer_reload;
            `IDX_BAUD_LOW_COUNT: rd_data = low_count;
            `IDX_INT_STATUS:     rd_data = {6'h00, int_status_reg};
            `IDX_INT_MASK:       rd_data = {6'h00, int_mask_reg};
            default:             rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            frame_length_select     <= 1'b0;
            multiproc_filter_enable <= 1'b0;
            receiver_enable         <= 1'b0;
            tx_ninth_bit            <= 1'b0;
            baud_timer_reload       <= `RST_RELOAD;
            timer_ctl_reg           <= `RST_TIMER_CONTROL;
            int_mask_reg            <= `RST_INT_MASK;
        end else if (wr_act) begin
            case (idx)
                `IDX_SERIAL_CONTROL: begin
                    frame_length_select     <= dat_i[`SCR_MODE_BIT];
                    multiproc_filter_enable <= dat_i[`SCR_MCE_BIT];
                    receiver_enable         <= dat_i[`SCR_REN_BIT];
                    tx_ninth_bit            <= dat_i[`SCR_TB8_BIT];
                end
                `IDX_TIMER_CONTROL: timer_ctl_reg     <= dat_i[3:0];
                `IDX_BAUD_RELOAD:   baud_timer_reload <= dat_i[7:0];
                `IDX_INT_MASK:      int_mask_reg      <= dat_i[1:0];
                default: ;
            endcase
        end
    end

    // Done flags: hardware set wins over a software clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_done_flag <= 1'b0;
            rx_done_flag <= 1'b0;
        end else begin
            if (tx_set)
                tx_done_flag <= 1'b1;                             // see R6
            else if (wr_ctl)
                tx_done_flag <= dat_i[`SCR_TI_BIT];               // see R6
            if (rx_set)
                rx_done_flag <= 1'b1;                             // see R6
            else if (wr_ctl)
                rx_done_flag <= dat_i[`SCR_RI_BIT];               // see R6
        end
    end

    // Sticky interrupt status, cleared by read, new events kept
    always @(posedge clk_i) begin
        if (rst_i) begin
            int_status_reg <= 2'b00;
        end else begin
            int_status_reg[`INT_RX_BIT] <= rx_set | (int_status_reg[`INT_RX_BIT]
                & ~(act & rd_clear_mask_reg[`INT_RX_BIT]));       // see R5
            int_status_reg[`INT_TX_BIT] <= tx_set | (int_status_reg[`INT_TX_BIT]
                & ~(act & rd_clear_mask_reg[`INT_TX_BIT]));       // see R5
        end
    end

    assign irq_o = |(int_status_reg & int_mask_reg);              // see R5

    ////////////////////////////////////////////////////////////////////////
    // Timer clock prescalers and source selection
    always @(posedge clk_i) begin
        if (rst_i) begin
            pre4_reg         <= 2'h0;
            pre12_reg        <= 4'h0;
            pre48_reg        <= 2'h0;
            extdiv_reg       <= 3'h0;
            ext_osc_prev_reg <= 1'b0;
            ext_pin_prev_reg <= 1'b0;
        end else begin
            pre4_reg         <= pre4_reg + 2'h1;
            pre12_reg        <= (pre12_reg == `PRE12_LAST) ? 4'h0 : pre12_reg + 4'h1;
            if (pre12_reg == `PRE12_LAST)
                pre48_reg <= pre48_reg + 2'h1;
            ext_osc_prev_reg <= ext_osc_i;
            ext_pin_prev_reg <= timer_ext_clock_input_i;
            if (ext_osc_i && !ext_osc_prev_reg)
                extdiv_reg <= extdiv_reg + 3'h1;
        end
    end

    // One-cycle timer tick from the chosen source
    always @* begin
        case (src_sel)                                            // see R12
            `SRC_CLK:          timer_tick = 1'b1;
            `SRC_CLK_DIV4:     timer_tick = (pre4_reg == `PRE4_LAST);
            `SRC_CLK_DIV12:    timer_tick = (pre12_reg == `PRE12_LAST);
            `SRC_CLK_DIV48:    timer_tick = (pre12_reg == `PRE12_LAST)
                                            && (pre48_reg == `PRE48_LAST);
            `SRC_EXTOSC_DIV8:  timer_tick = ext_osc_i && !ext_osc_prev_reg
                                            && (extdiv_reg == `EXTDIV_LAST);
            `SRC_EXT_PIN:      timer_tick = timer_ext_clock_input_i && !ext_pin_prev_reg;
            default:           timer_tick = 1'b0;
        endcase
    end

    // Baud = tick rate / (256 - reload) / 2, see R13
    baud_timer u_baud_timer (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .tick_i       (timer_tick),
        .enable_i     (tmr_en),
        .reload_i     (baud_timer_reload),
        .low_write_i  (wr_low),
        .low_data_i   (dat_i[7:0]),
        .rx_restart_i (rx_restart),
        .low_count_o  (low_count),
        .tx_ovf_o     (tx_ovf),
        .rx_ovf_o     (rx_ovf)
    );

    // Divide-by-two phases; receive phase realigned on start edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_phase_reg <= 1'b0;
            rx_phase_reg <= 1'b0;
        end else begin
            if (tx_ovf)
                tx_phase_reg <= ~tx_phase_reg;                    // see R9
            if (rx_restart)
                rx_phase_reg <= 1'b0;                             // see R11
            else if (rx_ovf)
                rx_phase_reg <= ~rx_phase_reg;                    // see R9
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter, independent of the receiver
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_shift_reg    <= 11'h7FF;
            tx_cnt_reg      <= 4'h0;
            tx_active_reg   <= 1'b0;
            serial_tx_pin_o <= 1'b1;                              // see R19
        end else if (wr_data) begin
            tx_active_reg <= 1'b1;                                // see R3
            tx_cnt_reg    <= 4'h0;
            tx_shift_reg  <= frame_length_select ?
                {1'b1, tx_ninth_bit, dat_i[7:0], 1'b0} :          // see R16
                {2'b11, dat_i[7:0], 1'b0};                        // see R15
        end else if (tx_active_reg && tx_bit_tick) begin         // see R1
            if (tx_cnt_reg == frame_bits(frame_length_select)) begin
                tx_active_reg <= 1'b0;
            end else begin
                serial_tx_pin_o <= tx_shift_reg[0];
                tx_shift_reg    <= {1'b1, tx_shift_reg[10:1]};
                tx_cnt_reg      <= tx_cnt_reg + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver: falling-edge start, mid-bit sampling, separate buffer
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_state_reg       <= RX_IDLE;
            rx_shift_reg       <= 10'h000;
            rx_cnt_reg         <= 4'h0;
            rx_prev_reg        <= 1'b1;
            serial_data_buffer <= 8'h00;
            rx_ninth_bit       <= 1'b0;
        end else begin
            rx_prev_reg <= serial_rx_pin_i;
            case (rx_state_reg)
                RX_IDLE: begin
                    if (rx_restart)                               // see R19
                        rx_state_reg <= RX_START;
                end
                RX_START: begin
                    if (rx_sample) begin
                        rx_cnt_reg   <= 4'h0;
                        rx_state_reg <= serial_rx_pin_i ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin                          // see R19
                        rx_shift_reg <= rx_shift_next;
                        rx_cnt_reg   <= rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg == frame_bits(frame_length_select) - 4'h2) begin
                            rx_state_reg <= RX_IDLE;
                            if (rx_set) begin                              // see R17
                                serial_data_buffer <= rx_load_data;        // see R2
                                rx_ninth_bit       <= rx_load_ninth;       // see R15
                            end
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // Transmit done strobe as the stop bit goes out
    assign tx_set = !rst_i && !wr_data && tx_active_reg && tx_bit_tick
                    && (tx_cnt_reg == frame_bits(frame_length_select) - 4'h1);  // see R18

    // Received word and ninth bit, loaded on the last sample if accepted
    assign rx_load_data  = frame_length_select ? rx_shift_next[7:0] : rx_shift_next[8:1];
    assign rx_load_ninth = frame_length_select ? rx_shift_next[8] : rx_shift_next[9];
    assign rx_set        = !rst_i && (rx_state_reg == RX_DATA) && rx_sample
                           && (rx_cnt_reg == frame_bits(frame_length_select) - 4'h2)
                           && !rx_done_flag
                           && (!multiproc_filter_enable || rx_load_ninth);          // see R17

endmodule // serial_port_zero

`default_nettype wire

// ==== pkg/serial_port_regs.vh ====
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

// Register word indexes (byte address = index * 4)
`define IDX_SERIAL_CONTROL   6'h00
`define IDX_SERIAL_DATA      6'h01
`define IDX_TIMER_CONTROL    6'h02
`define IDX_BAUD_RELOAD      6'h03
`define IDX_BAUD_LOW_COUNT   6'h04
`define IDX_INT_STATUS       6'h05
`define IDX_INT_MASK         6'h06

// Serial control register fields
`define SCR_MODE_BIT         7
`define SCR_RSVD_BIT         6
`define SCR_MCE_BIT          5
`define SCR_REN_BIT          4
`define SCR_TB8_BIT          3
`define SCR_RB8_BIT          2
`define SCR_TI_BIT           1
`define SCR_RI_BIT           0
`define SCR_RSVD_VAL         1'b1

// Timer control register fields
`define TCTL_EN_BIT          0
`define TCTL_SRC_MSB         3
`define TCTL_SRC_LSB         1

// Timer clock source codes
`define SRC_CLK              3'h0
`define SRC_CLK_DIV4         3'h1
`define SRC_CLK_DIV12        3'h2
`define SRC_CLK_DIV48        3'h3
`define SRC_EXTOSC_DIV8      3'h4
`define SRC_EXT_PIN          3'h5

// Interrupt status and mask bits
`define INT_RX_BIT           0
`define INT_TX_BIT           1

// Divider terminal counts
`define PRE4_LAST            2'h3
`define PRE12_LAST           4'hB
`define PRE48_LAST           2'h3
`define EXTDIV_LAST          3'h7
`define TIMER_TOP            8'hFF

// Frame lengths in bit periods, start bit included
`define FRAME8_BITS          4'hA
`define FRAME9_BITS          4'hB

// Reset values
`define RST_SERIAL_CONTROL   8'h00
`define RST_RELOAD           8'h00
`define RST_TIMER_CONTROL    4'h0
`define RST_INT_MASK         2'h0

`endif

// ==== verification/serial_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module serial_partner (
    input  wire logic clk_i,
    input  wire logic tx_line_i,
    output var  logic rx_line_o
);
    int         bitc = 4;
    logic       nine = 1'b0;
    logic [8:0] got = 9'h000;
    int         got_n = 0;
    logic [9:0] sh;

    // Line idles high between characters
    initial rx_line_o = 1'b1;

    // Sends start, data LSB first, optional ninth, stop
    task automatic send(input logic [7:0] d, input logic b9);
        logic [10:0] f;
        f = nine ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            @(posedge clk_i);
            rx_line_o <= f[i];
            repeat (bitc - 1) @(posedge clk_i);
        end
    endtask

    // Catches characters from the block, sampling near mid-bit
    always begin
        @(posedge clk_i iff tx_line_i === 1'b0);
        repeat (bitc / 2) @(posedge clk_i);
        for (int i = 0; i < (nine ? 10 : 9); i++) begin
            repeat (bitc) @(posedge clk_i);
            sh = {tx_line_i, sh[9:1]};
        end
        got = nine ? sh[8:0] : {sh[9], sh[8:1]};
        got_n++;
    end
endmodule // serial_partner
`default_nettype wire

// ==== verification/serial_port_zero_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module serial_port_zero_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic        irq_o,
    input wire logic        serial_tx_pin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Read answer seen on the bus
    wire rd_ack = ack_o && !we_i;

    ////////////////////////////////////////////////////////////////////////////////
    chk_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered after one wait cycle");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    chk_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    chk_unmapped_zero: assert property (rd_ack && adr_i[7:2] > 6'h06 |-> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_ctrl_fixed: assert property (rd_ack && adr_i[7:2] == 6'h00 |-> dat_o[6])
        else $error("control bit six reads zero");
    chk_tx_reset_idle: assert property ($past(rst_i) |-> serial_tx_pin_o)
        else $error("transmit line not idle after reset");
    chk_irq_reset: assert property ($past(rst_i) |-> !irq_o)
        else $error("interrupt raised after reset");
    chk_tx_bit_hold: assert property ($changed(serial_tx_pin_o) |=> $stable(serial_tx_pin_o))
        else $error("transmit bit shorter than two cycles");
endmodule // serial_port_zero_sva

bind serial_port_zero serial_port_zero_sva chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .ack_o(ack_o), .dat_o(dat_o), .irq_o(irq_o),
    .serial_tx_pin_o(serial_tx_pin_o)
);
`default_nettype wire

// ==== verification/serial_port_zero_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module serial_port_zero_tb;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
    logic        rx_pin, tx_pin, ext_osc = 1'b0, ext_tick = 1'b0;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd;
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;

    serial_port_zero dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .dat_o(dat_o),
        .irq_o(irq_o), .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin),
        .ext_osc_i(ext_osc), .timer_ext_clock_input_i(ext_tick)
    );
    serial_partner p (.clk_i(clk_i), .tx_line_i(tx_pin), .rx_line_o(rx_pin));

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // External timer sources toggle each cycle; run limit
    always @(posedge clk_i) begin
        ext_osc <= ~ext_osc;
        ext_tick <= ~ext_tick;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        sel_i <= 4'h1;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Waits end only by event or by the run limit
    task automatic wait_ctrl(input int b);
        do begin
            wb(1'b0, 8'h00, 8'h00);
        end while (rd[b] !== 1'b1);
    endtask

    task automatic wait_got(input int prev);
        while (p.got_n == prev) begin
            @(posedge clk_i);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        logic [7:0] a[5] = '{8'h00, 8'h0C, 8'h14, 8'h18, 8'h1C};
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, a[i], 8'h00);
            check(rd, (i == 0) ? 32'h0000_0040 : 32'h0000_0000);
        end
    endtask

    // One byte out per timer clock source
    task automatic t_tx_sources();
        int div[6] = '{1, 4, 12, 48, 16, 2};
        int prev;
        for (int s = 0; s < 6; s++) begin
            wb(1'b1, 8'h08, {4'h0, s[2:0], 1'b1});
            p.bitc = 2 * (256 - 8'hFE) * div[s];
            prev = p.got_n;
            wb(1'b1, 8'h04, 8'h5A ^ s[7:0]);
            wait_ctrl(1);
            check(32'(tx_pin), 32'h0000_0001);
            wait_got(prev);
            check(32'(p.got), 32'h0000_0100 | 32'(8'h5A ^ s[7:0]));
            wb(1'b1, 8'h00, 8'h10);
        end
        wb(1'b1, 8'h08, 8'h01);
        p.bitc = 4;
        wb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h0000_0000);
    endtask

    // Second byte shifts in while first is held; overrun drops
    task automatic t_rx_buffer();
        p.send(8'hA5, 1'b0);
        fork
            p.send(8'h3C, 1'b0);
        join_none
        repeat (12) @(posedge clk_i);
        wb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h0000_00A5);
        wb(1'b1, 8'h00, 8'h10);
        wait_ctrl(0);
        wait fork;
        wb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h0000_003C);
        p.send(8'hC3, 1'b0);
        repeat (4) @(posedge clk_i);
        wb(1'b0, 8'h00, 8'h00);
        check(rd, 32'h0000_0055);
        wb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h0000_003C);
        wb(1'b1, 8'h00, 8'h10);
    endtask

    // Nine-bit frames with address filter on
    task automatic t_nine();
        int prev;
        p.nine = 1'b1;
        wb(1'b1, 8'h00, 8'hB8);
        p.send(8'h11, 1'b0);
        repeat (8) @(posedge clk_i);
        wb(1'b0, 8'h00, 8'h00);
        check(rd, 32'h0000_00FC);
        p.send(8'h22, 1'b1);
        wait_ctrl(0);
        check(rd, 32'h0000_00FD);
        wb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h0000_0022);
        prev = p.got_n;
        wb(1'b1, 8'h04, 8'h81);
        wait_got(prev);
        check(32'(p.got), 32'h0000_0181);
        wb(1'b1, 8'h00, 8'h10);
        p.nine = 1'b0;
    endtask

    // Both directions at once, then interrupt and masking
    task automatic t_duplex_irq();
        int prev;
        wb(1'b1, 8'h18, 8'h03);
        prev = p.got_n;
        fork
            p.send(8'h96, 1'b0);
        join_none
        wb(1'b1, 8'h04, 8'h4B);
        wait_got(prev);
        wait_ctrl(0);
        wait fork;
        check(32'(irq_o), 32'h0000_0001);
        check(32'(p.got), 32'h0000_014B);
        wb(1'b0, 8'h04, 8'h00);
        check(rd, 32'h0000_0096);
        wb(1'b0, 8'h14, 8'h00);
        check(rd, 32'h0000_0003);
        check(32'(irq_o), 32'h0000_0000);
        wb(1'b0, 8'h00, 8'h00);
        check(rd, 32'h0000_0057);
        wb(1'b1, 8'h00, 8'h10);
        wb(1'b1, 8'h18, 8'h01);
        prev = p.got_n;
        wb(1'b1, 8'h04, 8'h0F);
        wait_got(prev);
        check(32'(irq_o), 32'h0000_0000);
        wb(1'b0, 8'h14, 8'h00);
        check(rd, 32'h0000_0002);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        dat_i = 32'h0000_0000;
        sel_i = 4'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_values();
        wb(1'b1, 8'h0C, 8'hFE);
        wb(1'b1, 8'h08, 8'h01);
        wb(1'b1, 8'h00, 8'h10);
        t_tx_sources();
        t_rx_buffer();
        t_nine();
        t_duplex_irq();
        end_of_test();
    end
endmodule // serial_port_zero_tb
`default_nettype wire
